// File: inc/aerc_defs.svh
`ifndef AERC_DEFS_SVH
`define AERC_DEFS_SVH

`define AERC_ADDR_W        12
`define AERC_OFF_SEV       12'h010c
`define AERC_OFF_CSTAT     12'h0110
`define AERC_OFF_CMASK     12'h0114
`define AERC_OFF_IRQ_STAT  12'h0130
`define AERC_OFF_IRQ_MASK  12'h0134

`define AERC_SEV_IMPL      32'h003f_f011
`define AERC_SEV_RST       32'h0006_2011
`define AERC_COR_IMPL      32'h0000_31c1
`define AERC_CMASK_RST     32'h0000_2000

`define AERC_COR_RX_ERR    0
`define AERC_COR_BAD_TLP   6
`define AERC_COR_BAD_DLLP  7
`define AERC_COR_RPL_ROLL  8
`define AERC_COR_RPL_TMO   12
`define AERC_COR_ADVISORY  13

`define AERC_IRQ_W         2
`define AERC_IRQ_REPORT    0
`define AERC_IRQ_SUPPR     1
`define AERC_IRQ_MASK_RST  2'h0

`endif

// File: inc/aerc_pkg.sv
package aerc_pkg;
    typedef enum logic [2:0] {
        AERC_SEL_NONE,
        AERC_SEL_SEV,
        AERC_SEL_CSTAT,
        AERC_SEL_CMASK,
        AERC_SEL_ISTAT,
        AERC_SEL_IMASK
    } aerc_sel_t;
endpackage : aerc_pkg

// File: design/aerc_w1c_bits.sv
`timescale 1ns/1ns
`default_nettype none
`include "aerc_defs.svh"

// Sticky bits: set wins over a write-one clear in the same cycle
module aerc_w1c_bits
#(
    parameter int         W    = 32,
    parameter logic [W-1:0] IMPL = '1
)
(
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] set_i,
    input  wire logic         clr_we,
    input  wire logic [W-1:0] clr_data,
    output var  logic [W-1:0] bits_r
);
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            if (IMPL[i])
            begin : g_impl
                always_ff @(posedge sys_clk)
                begin
                    if (!resetn)
                        bits_r[i] <= 1'b0;
                    else if (set_i[i])
                        bits_r[i] <= 1'b1;
                    else if (clr_we && clr_data[i])
                        bits_r[i] <= 1'b0;
                end
            end
            else
            begin : g_rsvd
                // Own flop per bit so no bit mixes process kinds
                always_ff @(posedge sys_clk)
                    bits_r[i] <= 1'b0;
            end
        end
    endgenerate
endmodule : aerc_w1c_bits

`default_nettype wire

// File: design/aerc_rw_reg.sv
`timescale 1ns/1ns
`default_nettype none
`include "aerc_defs.svh"

// Plain read/write register; bits outside IMPL hold zero
module aerc_rw_reg
#(
    parameter int           W    = 32,
    parameter logic [W-1:0] IMPL = '1,
    parameter logic [W-1:0] RST  = '0
)
(
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic         we,
    input  wire logic [W-1:0] wdata,
    output var  logic [W-1:0] q_r
);
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            q_r <= RST & IMPL;
        else if (we)
            q_r <= wdata & IMPL;
    end
endmodule : aerc_rw_reg

`default_nettype wire

// File: design/aerc_err_regs.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "aerc_defs.svh"

module aerc_err_regs
    import aerc_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     resetn,
    input  wire logic [`AERC_ADDR_W-1:0]  addr,
    input  wire logic [31:0]              wdata,
    input  wire logic                     wr_stb,
    input  wire logic                     rd_stb,
    output var  logic [31:0]              rdata,
    input  wire logic                     ev_rx_err,
    input  wire logic                     ev_bad_tlp,
    input  wire logic                     ev_bad_dllp,
    input  wire logic                     ev_replay_roll,
    input  wire logic                     ev_replay_tmo,
    input  wire logic                     ev_advisory,
    output var  logic [31:0]              severity,
    output var  logic [31:0]              cor_log_req,
    output var  logic                     cor_msg_req,
    output var  logic                     irq
);
    // ==========================================================
    // Address decode
    // ==========================================================
    function automatic aerc_sel_t dec(input logic [`AERC_ADDR_W-1:0] a);
        if (a == `AERC_OFF_SEV)
            return AERC_SEL_SEV;
        else if (a == `AERC_OFF_CSTAT)
            return AERC_SEL_CSTAT;
        else if (a == `AERC_OFF_CMASK)
            return AERC_SEL_CMASK;
        else if (a == `AERC_OFF_IRQ_STAT)
            return AERC_SEL_ISTAT;
        else if (a == `AERC_OFF_IRQ_MASK)
            return AERC_SEL_IMASK;
        else
            return AERC_SEL_NONE;
    endfunction : dec

    aerc_sel_t sel;
    assign sel = dec(addr);

    // ==========================================================
    // Error registers
    // ==========================================================
    logic [31:0] sev_r;
    logic [31:0] cstat_r;
    logic [31:0] cmask_r;
    logic [31:0] ev_vec;

    always_comb
    begin
        ev_vec = 32'h0000_0000;
        ev_vec[`AERC_COR_RX_ERR]   = ev_rx_err;
        ev_vec[`AERC_COR_BAD_TLP]  = ev_bad_tlp;
        ev_vec[`AERC_COR_BAD_DLLP] = ev_bad_dllp;
        ev_vec[`AERC_COR_RPL_ROLL] = ev_replay_roll;
        ev_vec[`AERC_COR_RPL_TMO]  = ev_replay_tmo;
        ev_vec[`AERC_COR_ADVISORY] = ev_advisory;
    end

    aerc_rw_reg #(
        .W    (32),
        .IMPL (`AERC_SEV_IMPL),
        .RST  (`AERC_SEV_RST)
    ) u_sev (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .we      (wr_stb && sel == AERC_SEL_SEV),
        .wdata   (wdata),
        .q_r     (sev_r)
    );

    aerc_w1c_bits #(
        .W    (32),
        .IMPL (`AERC_COR_IMPL)
    ) u_cstat (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .set_i    (ev_vec),
        .clr_we   (wr_stb && sel == AERC_SEL_CSTAT),
        .clr_data (wdata),
        .bits_r   (cstat_r)
    );

    aerc_rw_reg #(
        .W    (32),
        .IMPL (`AERC_COR_IMPL),
        .RST  (`AERC_CMASK_RST)
    ) u_cmask (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .we      (wr_stb && sel == AERC_SEL_CMASK),
        .wdata   (wdata),
        .q_r     (cmask_r)
    );

    // ==========================================================
    // Logging and messaging requests
    // ==========================================================
    logic [31:0] ev_unmasked;
    logic [31:0] ev_masked;
    assign ev_unmasked = ev_vec & ~cmask_r;
    assign ev_masked   = ev_vec & cmask_r;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            cor_log_req <= 32'h0000_0000;
        else
            cor_log_req <= ev_unmasked;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            cor_msg_req <= 1'b0;
        else
            cor_msg_req <= |ev_unmasked;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            severity <= `AERC_SEV_RST;
        else
            severity <= sev_r;
    end

    // ==========================================================
    // Interrupt status and mask
    // ==========================================================
    logic [`AERC_IRQ_W-1:0] istat_r;
    logic [`AERC_IRQ_W-1:0] imask_r;
    logic [`AERC_IRQ_W-1:0] iset;

    always_comb
    begin
        iset = '0;
        iset[`AERC_IRQ_REPORT] = |ev_unmasked;
        iset[`AERC_IRQ_SUPPR]  = |ev_masked;
    end

    aerc_w1c_bits #(
        .W    (`AERC_IRQ_W),
        .IMPL ('1)
    ) u_istat (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .set_i    (iset),
        .clr_we   (wr_stb && sel == AERC_SEL_ISTAT),
        .clr_data (wdata[`AERC_IRQ_W-1:0]),
        .bits_r   (istat_r)
    );

    aerc_rw_reg #(
        .W    (`AERC_IRQ_W),
        .IMPL ('1),
        .RST  (`AERC_IRQ_MASK_RST)
    ) u_imask (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .we      (wr_stb && sel == AERC_SEL_IMASK),
        .wdata   (wdata[`AERC_IRQ_W-1:0]),
        .q_r     (imask_r)
    );

    // Mask bit one enables; irq registers the next status value, so it has no lag behind istat_r
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |((iset | (istat_r & ~(
                {`AERC_IRQ_W{wr_stb && sel == AERC_SEL_ISTAT}}
                & wdata[`AERC_IRQ_W-1:0]))) & imask_r);
    end

    // ==========================================================
    // Read port
    // ==========================================================
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            rdata <= 32'h0000_0000;
        else if (rd_stb)
        begin
            if (sel == AERC_SEL_SEV)
                rdata <= sev_r;
            else if (sel == AERC_SEL_CSTAT)
                rdata <= cstat_r;
            else if (sel == AERC_SEL_CMASK)
                rdata <= cmask_r;
            else if (sel == AERC_SEL_ISTAT)
                rdata <= {{(32-`AERC_IRQ_W){1'b0}}, istat_r};
            else if (sel == AERC_SEL_IMASK)
                rdata <= {{(32-`AERC_IRQ_W){1'b0}}, imask_r};
            else
                rdata <= 32'h0000_0000;
        end
        else
            rdata <= 32'h0000_0000;
    end

    // ==========================================================
    // Checks
    // ==========================================================
    // Severity reset
    property p_sev_reset;
        @(posedge sys_clk) !resetn |=> sev_r == `AERC_SEV_RST;
    endproperty
    a_sev_reset: assert property (p_sev_reset)
        else $error("severity reset value wrong");

    property p_sev_write;
        @(posedge sys_clk) disable iff (!resetn)
        wr_stb && sel == AERC_SEL_SEV
        |=> sev_r == ($past(wdata) & `AERC_SEV_IMPL);
    endproperty
    a_sev_write: assert property (p_sev_write)
        else $error("severity write not stored");

    property p_rx_set;
        @(posedge sys_clk) disable iff (!resetn)
        ev_rx_err |=> cstat_r[`AERC_COR_RX_ERR];
    endproperty
    a_rx_set: assert property (p_rx_set)
        else $error("receiver error bit not set");

    property p_dllp_sticky;
        @(posedge sys_clk) disable iff (!resetn)
        cstat_r[`AERC_COR_BAD_DLLP] && !(wr_stb && sel == AERC_SEL_CSTAT)
        |=> cstat_r[`AERC_COR_BAD_DLLP];
    endproperty
    a_dllp_sticky: assert property (p_dllp_sticky)
        else $error("bad dllp bit lost");

    property p_tmo_set;
        @(posedge sys_clk) disable iff (!resetn)
        ev_replay_tmo |=> cstat_r[`AERC_COR_RPL_TMO];
    endproperty
    a_tmo_set: assert property (p_tmo_set)
        else $error("replay timeout bit not set");

    property p_rsvd;
        @(posedge sys_clk) disable iff (!resetn)
        (cstat_r & ~`AERC_COR_IMPL) == 32'h0000_0000;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved status bit set");

    property p_mask_msg;
        @(posedge sys_clk) disable iff (!resetn)
        (ev_vec & ~cmask_r) == 32'h0000_0000 |=> !cor_msg_req;
    endproperty
    a_mask_msg: assert property (p_mask_msg)
        else $error("masked error reported");

    property p_adv_mask;
        @(posedge sys_clk) !resetn |=> cmask_r == `AERC_CMASK_RST;
    endproperty
    a_adv_mask: assert property (p_adv_mask)
        else $error("mask reset value wrong");

    property p_mask_status;
        @(posedge sys_clk) disable iff (!resetn)
        ev_advisory && cmask_r[`AERC_COR_ADVISORY]
        |=> cstat_r[`AERC_COR_ADVISORY] && !cor_log_req[`AERC_COR_ADVISORY];
    endproperty
    a_mask_status: assert property (p_mask_status)
        else $error("masked advisory not recorded");

    c_rx_report: cover property (@(posedge sys_clk) disable iff (!resetn)
        ev_rx_err ##1 cor_msg_req);
    c_clear: cover property (@(posedge sys_clk) disable iff (!resetn)
        cstat_r[`AERC_COR_BAD_TLP] ##1 !cstat_r[`AERC_COR_BAD_TLP]);
    c_irq: cover property (@(posedge sys_clk) disable iff (!resetn) irq);
endmodule : aerc_err_regs

`default_nettype wire

// File: tb/aerc_ev_src.sv
`timescale 1ns/1ns
`default_nettype none

// ========================================
// Link-side error event source
// Bits: rx, bad tlp, bad dllp, roll, tmo, adv
module aerc_ev_src
(
    input  wire logic       sys_clk,
    output var  logic [5:0] ev
);
    initial ev = 6'h00;

    // One high cycle per call; idle low between
    task automatic fire(input logic [5:0] v);
        @(posedge sys_clk);
        ev <= v;
        @(posedge sys_clk);
        ev <= 6'h00;
    endtask : fire
endmodule : aerc_ev_src

`default_nettype wire

// File: tb/tb_pcie_error_severity_correctable_log.sv
`timescale 1ns/1ns
`default_nettype none
`include "aerc_defs.svh"

module tb_pcie_error_severity_correctable_log;
    logic        sys_clk;
    logic        resetn;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata;
    logic [31:0] severity;
    logic [31:0] cor_log_req;
    logic        cor_msg_req;
    logic        irq;
    logic [5:0]  ev;
    logic        pend = 1'b0;
    logic [31:0] exp_q[$];
    int          n_errors;
    int          checks;
    int          pos[6] = '{0, 6, 7, 8, 12, 13};

    aerc_ev_src i_src (.sys_clk(sys_clk), .ev(ev));

    aerc_err_regs i_dut (
        .sys_clk        (sys_clk),
        .resetn         (resetn),
        .addr           (addr),
        .wdata          (wdata),
        .wr_stb         (wr_stb),
        .rd_stb         (rd_stb),
        .rdata          (rdata),
        .ev_rx_err      (ev[0]),
        .ev_bad_tlp     (ev[1]),
        .ev_bad_dllp    (ev[2]),
        .ev_replay_roll (ev[3]),
        .ev_replay_tmo  (ev[4]),
        .ev_advisory    (ev[5]),
        .severity       (severity),
        .cor_log_req    (cor_log_req),
        .cor_msg_req    (cor_msg_req),
        .irq            (irq)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ========================================
    // Compare and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk);
        rd_stb <= 1'b0;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic finish_test;
        $display("counts: %0d checks, %0d errors", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    // ========================================
    // Read monitor: data stands only in the cycle after the strobe
    always @(posedge sys_clk)
    begin
        if (pend && exp_q.size() > 0)
            chk(rdata, exp_q.pop_front(), "read");
        pend <= rd_stb;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        finish_test();
    end

    // ========================================
    // Tests
    initial
    begin
        logic [31:0] r;
        logic [31:0] b;
        void'($urandom(96));
        resetn = 1'b0;
        addr   = 12'h000;
        wdata  = 32'h0000_0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(`AERC_OFF_SEV, 32'h0006_2011);
        rd(`AERC_OFF_CSTAT, 32'h0000_0000);
        rd(`AERC_OFF_CMASK, 32'h0000_2000);
        rd(12'h0200, 32'h0000_0000);
        settle(1);
        chk(severity, 32'h0006_2011, "sev port");
        $display("test reset values done");

        for (int i = 0; i < 4; i++)
        begin
            r = $urandom;
            wr(`AERC_OFF_SEV, r);
            rd(`AERC_OFF_SEV, r & 32'h003f_f011);
            settle(1);
            chk(severity, r & 32'h003f_f011, "sev port");
        end
        $display("test severity done");

        // Advisory is masked out of reset, the others report
        for (int i = 0; i < 6; i++)
        begin
            b = 32'h0000_0001 << pos[i];
            i_src.fire(6'h01 << i);
            #1;
            chk(cor_log_req, (i == 5) ? 32'h0 : b, "log");
            chk({31'h0, cor_msg_req}, {31'h0, i != 5}, "msg");
            rd(`AERC_OFF_CSTAT, b);
            wr(`AERC_OFF_CSTAT, ~b);
            rd(`AERC_OFF_CSTAT, b);
            wr(`AERC_OFF_CSTAT, b);
            rd(`AERC_OFF_CSTAT, 32'h0000_0000);
        end
        $display("test events done");

        wr(`AERC_OFF_CMASK, 32'hffff_ffff);
        rd(`AERC_OFF_CMASK, 32'h0000_31c1);
        i_src.fire(6'h3f);
        #1;
        chk(cor_log_req, 32'h0000_0000, "masked log");
        chk({31'h0, cor_msg_req}, 32'h0, "masked msg");
        rd(`AERC_OFF_CSTAT, 32'h0000_31c1);
        wr(`AERC_OFF_CSTAT, 32'hffff_ffff);
        wr(`AERC_OFF_CMASK, 32'h0000_0001);
        i_src.fire(6'h03);
        #1;
        chk(cor_log_req, 32'h0000_0040, "part mask");
        rd(`AERC_OFF_CSTAT, 32'h0000_0041);
        wr(`AERC_OFF_CSTAT, 32'h0000_0041);
        $display("test masking done");

        // Earlier tests left both interrupt causes pending
        wr(`AERC_OFF_CMASK, 32'h0000_0000);
        rd(`AERC_OFF_IRQ_STAT, 32'h0000_0003);
        wr(`AERC_OFF_IRQ_STAT, 32'h0000_0003);
        wr(`AERC_OFF_IRQ_MASK, 32'h0000_0001);
        settle(1);
        chk({31'h0, irq}, 32'h0, "irq idle");
        i_src.fire(6'h04);
        #1;
        chk({31'h0, irq}, 32'h1, "irq set");
        wr(`AERC_OFF_IRQ_STAT, 32'h0000_0001);
        settle(2);
        chk({31'h0, irq}, 32'h0, "irq clear");
        wr(`AERC_OFF_IRQ_MASK, 32'h0000_0000);
        i_src.fire(6'h04);
        #1;
        chk({31'h0, irq}, 32'h0, "irq masked");
        rd(`AERC_OFF_IRQ_STAT, 32'h0000_0001);
        wr(`AERC_OFF_IRQ_MASK, 32'h0000_0001);
        rd(`AERC_OFF_IRQ_MASK, 32'h0000_0001);
        settle(2);
        chk({31'h0, irq}, 32'h1, "irq unmask");
        settle(3);
        $display("test interrupt done");
        finish_test();
    end
endmodule : tb_pcie_error_severity_correctable_log

`default_nettype wire
